// File: hw/kvm_secure_channel_switch_control.v
// Channel selection, routing gates, session control and tamper handling
`timescale 1ns/1ns
`include "kvm_switch_regs.vh"
module kvm_secure_channel_switch_control #(
	parameter        N               = 4,
	parameter        CW              = 2,
	parameter        VW              = 8,
	parameter        MULTI_VIEWER    = 0,
	parameter [31:0] AUTH_OFF_CYCLES = `KVM_AUTH_OFF_CYC,
	parameter [31:0] DEBOUNCE_CYCLES = `KVM_DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire            clk_sys,
	input  wire            reset,
	// User controls (pins)
	input  wire [N-1:0]    panelBtn,
	input  wire [N-1:0]    remoteBtn,
	input  wire            remoteAttached,
	// Guard gesture request (internal, same clock)
	input  wire            guardReqValid,
	input  wire [CW-1:0]   guardReqChan,
	// Self-test and anti-tamper (pins)
	input  wire            selfTestDone,
	input  wire            selfTestPass,
	input  wire            tamperSense,
	input  wire            batteryFault,
	input  wire            tamperRecord,
	// Authentication port status (pins)
	input  wire            cardPresent,
	input  wire            authDevPresent,
	// Keyboard stream, peripheral to host
	input  wire            kbdInValid,
	input  wire [7:0]      kbdInData,
	output wire            kbdInReady,
	output wire [N-1:0]    kbdOutValid,
	output wire [7:0]      kbdOutData,
	input  wire [N-1:0]    kbdOutReady,
	// Mouse stream, peripheral to host
	input  wire            msInValid,
	input  wire [7:0]      msInData,
	output wire [N-1:0]    msOutValid,
	output wire [7:0]      msOutData,
	// Authentication device data, both directions
	input  wire            uaDevValid,
	input  wire [7:0]      uaDevData,
	output wire [N-1:0]    uaHostValid,
	output wire [7:0]      uaHostData,
	input  wire [N-1:0]    uaHostInValid,
	input  wire [N*8-1:0]  uaHostInData,
	output wire            uaDevOutValid,
	output wire [7:0]      uaDevOutData,
	output wire            authPower,
	output wire            authSessionEnd,
	// Video, computer to display
	input  wire [N-1:0]    vidInValid,
	input  wire [N*VW-1:0] vidInData,
	output wire            vidOutValid,
	output wire [VW-1:0]   vidOutData,
	// Video sideband classification
	input  wire            auxValid,
	input  wire            auxDir,
	input  wire [2:0]      auxKind,
	output wire            auxPass,
	output wire            auxBlock,
	input  wire            hpdDisplay,
	output wire [N-1:0]    hpdHost,
	// Indicators and status
	output wire [N-1:0]    ledPanel,
	output wire [N-1:0]    ledRemote,
	output wire [CW-1:0]   osdChan,
	output wire            failLed,
	output wire            tamperLatched,
	output wire            secureState
);
	// ****************************************
	// Constants and helpers
	// ****************************************
	localparam PW = 2*N + 10;
	localparam [2:0] ST_TEST = 3'b001;
	localparam [2:0] ST_RUN  = 3'b010;
	localparam [2:0] ST_FAIL = 3'b100;
	localparam [CW-1:0] SEL_BOOT = `KVM_SEL_RESET;

	// Lowest set bit's index
	function [CW-1:0] firstSet;
		input [N-1:0] v;
		integer k;
		begin
			firstSet = {CW{1'b0}};
			for (k = N-1; k >= 0; k = k - 1)
				if (v[k])
					firstSet = k[CW-1:0];
		end
	endfunction

	// Sideband kinds allowed through, by direction
	function auxAllowed;
		input       dir;
		input [2:0] kind;
		begin
			case (kind)
				`KVM_AUX_EDID:   auxAllowed = (dir == `KVM_DIR_TO_HOST);
				`KVM_AUX_HPD:    auxAllowed = (dir == `KVM_DIR_TO_HOST);
				`KVM_AUX_LTRAIN: auxAllowed = 1'b1;
				default:         auxAllowed = 1'b0;
			endcase
		end
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg  [PW-1:0] pinMeta_ff;
	reg  [PW-1:0] pinSync_ff;
	wire [PW-1:0] pinRaw;

	assign pinRaw = {hpdDisplay, tamperRecord, remoteAttached, authDevPresent, cardPresent,
		tamperSense, batteryFault, selfTestPass, selfTestDone, 1'b0, remoteBtn, panelBtn};

	// Two flops before any logic reads a pin
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pinMeta_ff <= {PW{1'b0}};
			pinSync_ff <= {PW{1'b0}};
		end else begin
			pinMeta_ff <= pinRaw;
			pinSync_ff <= pinMeta_ff;
		end
	end

	wire [N-1:0] panelSync   = pinSync_ff[N-1:0];
	wire [N-1:0] remoteSync  = pinSync_ff[2*N-1:N];
	wire         testDoneS   = pinSync_ff[2*N+1];
	wire         testPassS   = pinSync_ff[2*N+2];
	wire         batteryS    = pinSync_ff[2*N+3];
	wire         tamperS     = pinSync_ff[2*N+4];
	wire         cardS       = pinSync_ff[2*N+5];
	wire         authDevS    = pinSync_ff[2*N+6];
	wire         remoteAttS  = pinSync_ff[2*N+7];
	wire         recordS     = pinSync_ff[2*N+8];
	wire         hpdS        = pinSync_ff[2*N+9];

	// ****************************************
	// Debounce, one counter per button group
	// ****************************************
	wire [2*N-1:0] dbRaw = {remoteSync, panelSync};
	wire [2*N-1:0] dbPress;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gDeb
			reg [N-1:0] last_ff;
			reg [N-1:0] stable_ff;
			reg [N-1:0] prev_ff;
			reg [31:0]  cnt_ff;
			// Group must hold still for the settling time before it counts
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					last_ff   <= {N{1'b0}};
					stable_ff <= {N{1'b0}};
					prev_ff   <= {N{1'b0}};
					cnt_ff    <= 32'h00000000;
				end else begin
					prev_ff <= stable_ff;
					if (dbRaw[g*N +: N] != last_ff) begin
						last_ff <= dbRaw[g*N +: N];
						cnt_ff  <= 32'h00000000;
					end else if (cnt_ff >= DEBOUNCE_CYCLES - 32'h00000001) begin
						stable_ff <= last_ff;
					end else begin
						cnt_ff <= cnt_ff + 32'h00000001;
					end
				end
			end
			assign dbPress[g*N +: N] = stable_ff & ~prev_ff;
		end
	endgenerate

	// ****************************************
	// Switch request arbitration
	// ****************************************
	reg  [2:0]    state_ff;
	reg  [2:0]    nxt_state;
	reg  [CW-1:0] sel_ff;
	wire          active = (state_ff == ST_RUN);
	// Remote takes authority whenever attached; panel presses are then ignored
	wire [N-1:0]  userPress = remoteAttS ? dbPress[2*N-1:N] : dbPress[N-1:0];
	// Only express user sources exist; no host or hotkey path reaches here
	wire          guardOk   = (MULTI_VIEWER != 0) && guardReqValid;
	wire          reqValid  = (|userPress) || guardOk;
	wire [CW-1:0] reqChan   = (|userPress) ? firstSet(userPress) : guardReqChan;
	// Same channel again is a no-op
	wire          doSwitch  = active && reqValid && (reqChan != sel_ff);

	// ****************************************
	// Security state machine
	// ****************************************
	reg  tamper_ff;
	wire tamperHit = tamperS || batteryS || recordS;

	// Self-test is only looked at once, before the first run
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_TEST: begin
				if (tamperHit || tamper_ff)
					nxt_state = ST_FAIL;
				else if (testDoneS)
					nxt_state = testPassS ? ST_RUN : ST_FAIL;
			end
			ST_RUN: begin
				if (tamperHit)
					nxt_state = ST_FAIL;
			end
			ST_FAIL: nxt_state = ST_FAIL;
			default: nxt_state = ST_FAIL;
		endcase
	end

	// State, sticky tamper status and shared selection
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_ff  <= ST_TEST;
			tamper_ff <= 1'b0;
			sel_ff    <= SEL_BOOT;
		end else begin
			state_ff <= nxt_state;
			if (tamperHit)
				tamper_ff <= 1'b1;
			if (doSwitch)
				sel_ff <= reqChan;
		end
	end

	// ****************************************
	// Authentication session and power
	// ****************************************
	reg        cardPrev_ff;
	reg        authDevPrev_ff;
	reg        sessEnd_ff;
	reg [31:0] offCnt_ff;

	// Removal edges and switches end the session; switch also reloads off time
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cardPrev_ff    <= 1'b0;
			authDevPrev_ff <= 1'b0;
			sessEnd_ff     <= 1'b0;
			offCnt_ff      <= 32'h00000000;
		end else begin
			cardPrev_ff    <= cardS;
			authDevPrev_ff <= authDevS;
			sessEnd_ff     <= doSwitch
				|| (cardPrev_ff && !cardS)
				|| (authDevPrev_ff && !authDevS);
			if (doSwitch)
				offCnt_ff <= AUTH_OFF_CYCLES;
			else if (offCnt_ff != 32'h00000000)
				offCnt_ff <= offCnt_ff - 32'h00000001;
		end
	end

	assign authSessionEnd = sessEnd_ff;
	assign authPower      = active && (offCnt_ff == 32'h00000000);
	wire   uaOpen         = authPower;

	// ****************************************
	// Data routing gates
	// ****************************************
	wire [N-1:0] selHot = active ? ({{(N-1){1'b0}}, 1'b1} << sel_ff) : {N{1'b0}};

	// Keyboard bytes sit only in volatile flops and are wiped on switch or failure
	wire       kbdBufValid;
	wire [7:0] kbdBufData;
	kbd_byte_buffer #(
		.DW    (8),
		.DEPTH (4),
		.AW    (2)
	) uKbdBuf (
		.clk_sys (clk_sys),
		.reset   (reset),
		.purge   (doSwitch || !active),
		.wrValid (kbdInValid),
		.wrData  (kbdInData),
		.wrReady (kbdInReady),
		.rdValid (kbdBufValid),
		.rdData  (kbdBufData),
		.rdReady (|(kbdOutReady & selHot))
	);
	assign kbdOutValid = {N{kbdBufValid}} & selHot;
	assign kbdOutData  = kbdBufData;

	reg [N-1:0]  msValid_ff;
	reg [7:0]    msData_ff;
	reg [N-1:0]  uaHostValid_ff;
	reg [7:0]    uaHostData_ff;
	reg          uaDevValid_ff;
	reg [7:0]    uaDevData_ff;
	reg          vidValid_ff;
	reg [VW-1:0] vidData_ff;
	reg [N-1:0]  hpd_ff;

	// Forward-only registered paths; no return path exists for keyboard, mouse or video
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			msValid_ff     <= {N{1'b0}};
			msData_ff      <= 8'h00;
			uaHostValid_ff <= {N{1'b0}};
			uaHostData_ff  <= 8'h00;
			uaDevValid_ff  <= 1'b0;
			uaDevData_ff   <= 8'h00;
			vidValid_ff    <= 1'b0;
			vidData_ff     <= {VW{1'b0}};
			hpd_ff         <= {N{1'b0}};
		end else begin
			msValid_ff <= {N{msInValid}} & selHot;
			msData_ff  <= msInData;
			// Authentication uses its own registers only
			uaHostValid_ff <= {N{uaDevValid && uaOpen}} & selHot;
			uaHostData_ff  <= uaDevData;
			uaDevValid_ff  <= uaOpen && |(uaHostInValid & selHot);
			uaDevData_ff   <= uaHostInData[sel_ff*8 +: 8];
			vidValid_ff    <= active && vidInValid[sel_ff];
			vidData_ff     <= vidInData[sel_ff*VW +: VW];
			hpd_ff         <= {N{hpdS}} & selHot;
		end
	end

	assign msOutValid    = msValid_ff;
	assign msOutData     = msData_ff;
	assign uaHostValid   = uaHostValid_ff;
	assign uaHostData    = uaHostData_ff;
	assign uaDevOutValid = uaDevValid_ff;
	assign uaDevOutData  = uaDevData_ff;
	assign vidOutValid   = vidValid_ff;
	assign vidOutData    = vidData_ff;
	assign hpdHost       = hpd_ff;

	// Sideband: only display EDID reads reach internal memory from outside
	assign auxPass  = auxValid && active && auxAllowed(auxDir, auxKind);
	assign auxBlock = auxValid && !auxPass;

	// ****************************************
	// Indicators
	// ****************************************
	reg [N-1:0]  ledPanel_ff;
	reg [N-1:0]  ledRemote_ff;
	reg [CW-1:0] osd_ff;
	reg          fail_ff;

	// Channel lamps and OSD derive from the one selection register; the fail lamp derives from the state
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ledPanel_ff  <= {N{1'b0}};
			ledRemote_ff <= {N{1'b0}};
			osd_ff       <= {CW{1'b0}};
			fail_ff      <= 1'b0;
		end else begin
			ledPanel_ff  <= selHot;
			ledRemote_ff <= remoteAttS ? selHot : {N{1'b0}};
			osd_ff       <= sel_ff;
			fail_ff      <= (state_ff == ST_FAIL);
		end
	end

	assign ledPanel      = ledPanel_ff;
	assign ledRemote     = ledRemote_ff;
	assign osdChan       = osd_ff;
	assign failLed       = fail_ff;
	assign tamperLatched = tamper_ff;
	assign secureState   = (state_ff == ST_FAIL);
endmodule // kvm_secure_channel_switch_control

// File: hw/kvm_switch_regs.vh
// Constants shared by the channel switch control logic
`ifndef KVM_SWITCH_REGS_VH
`define KVM_SWITCH_REGS_VH

// Clock rate in kHz (100 MHz)
`define KVM_CLK_KHZ       100000
// Authentication power-off time in ms, least value
`define KVM_AUTH_OFF_MS   1000
// Contact debounce settling time in ms
`define KVM_DEBOUNCE_MS   5
// Derived cycle counts
`define KVM_AUTH_OFF_CYC  (`KVM_AUTH_OFF_MS * `KVM_CLK_KHZ)
`define KVM_DEBOUNCE_CYC  (`KVM_DEBOUNCE_MS * `KVM_CLK_KHZ)

// Channel index after boot (first computer)
`define KVM_SEL_RESET     0

// Video sideband transaction kinds
`define KVM_AUX_EDID      3'h0
`define KVM_AUX_HPD       3'h1
`define KVM_AUX_LTRAIN    3'h2
`define KVM_AUX_CEC       3'h3
`define KVM_AUX_HDCP      3'h4
`define KVM_AUX_MCCS      3'h5
// Sideband direction: display toward computer
`define KVM_DIR_TO_HOST   1'b1

`endif

// File: hw/kbd_byte_buffer.v
// Volatile keyboard byte buffer with a wipe on purge
`timescale 1ns/1ns
module kbd_byte_buffer #(
	parameter DW    = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	// Clock and reset
	input  wire          clk_sys,
	input  wire          reset,
	// Wipe all contents
	input  wire          purge,
	// Filling side
	input  wire          wrValid,
	input  wire [DW-1:0] wrData,
	output wire          wrReady,
	// Draining side
	output wire          rdValid,
	output wire [DW-1:0] rdData,
	input  wire          rdReady
);
	reg [DW-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0] wp_ff;
	reg [AW-1:0] rp_ff;
	reg [AW:0]   count_ff;
	reg [DW-1:0] rdData_ff;
	reg          rdValid_ff;
	wire         doWrite;
	wire         doLoad;
	integer      i;
	localparam [AW:0] FULL = DEPTH;

	// Stall the source while full or wiping
	assign wrReady = (count_ff != FULL) && !purge;
	assign doWrite = wrValid && wrReady;
	assign doLoad  = !purge && (count_ff != {(AW+1){1'b0}}) && (!rdValid_ff || rdReady);
	assign rdValid = rdValid_ff;
	assign rdData  = rdData_ff;

	// Storage, pointers and output register; purge zeroes every byte, not just pointers
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem_ff[i] <= {DW{1'b0}};
			wp_ff      <= {AW{1'b0}};
			rp_ff      <= {AW{1'b0}};
			count_ff   <= {(AW+1){1'b0}};
			rdData_ff  <= {DW{1'b0}};
			rdValid_ff <= 1'b0;
		end else if (purge) begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem_ff[i] <= {DW{1'b0}};
			wp_ff      <= {AW{1'b0}};
			rp_ff      <= {AW{1'b0}};
			count_ff   <= {(AW+1){1'b0}};
			rdData_ff  <= {DW{1'b0}};
			rdValid_ff <= 1'b0;
		end else begin
			if (doWrite) begin
				mem_ff[wp_ff] <= wrData;
				wp_ff         <= wp_ff + 1'b1;
			end
			if (doLoad) begin
				rdData_ff     <= mem_ff[rp_ff];
				mem_ff[rp_ff] <= {DW{1'b0}}; // Leave no copy behind
				rp_ff         <= rp_ff + 1'b1;
				rdValid_ff    <= 1'b1;
			end else if (rdReady) begin
				rdValid_ff <= 1'b0;
			end
			if (doWrite && !doLoad)
				count_ff <= count_ff + 1'b1;
			else if (!doWrite && doLoad)
				count_ff <= count_ff - 1'b1;
		end
	end
endmodule // kbd_byte_buffer

// File: verif/kvm_switch_checker.sv
// Port-level assertions for the channel switch control block
`timescale 1ns/1ns
`include "kvm_switch_regs.vh"
module kvm_switch_checker #(
	parameter        N               = 4,
	parameter        CW              = 2,
	parameter [31:0] AUTH_OFF_CYCLES = `KVM_AUTH_OFF_CYC
) (
	// Clock and reset
	input wire          clk_sys,
	input wire          reset,
	// Video sideband
	input wire          auxValid,
	input wire          auxDir,
	input wire [2:0]    auxKind,
	input wire          auxPass,
	// Data path valids
	input wire [N-1:0]  kbdOutValid,
	input wire [N-1:0]  msOutValid,
	input wire [N-1:0]  uaHostValid,
	input wire          uaDevOutValid,
	input wire          vidOutValid,
	// Indicators, session and state
	input wire [N-1:0]  ledPanel,
	input wire [N-1:0]  ledRemote,
	input wire [CW-1:0] osdChan,
	input wire          authPower,
	input wire          authSessionEnd,
	input wire          failLed,
	input wire          tamperLatched,
	input wire          secureState
);
	// ****************************************
	// Helper logic and properties
	// ****************************************
	reg        armed_ff;
	reg [31:0] offCnt_ff;

	// Count power-off cycles only after power was once on, so boot is not judged
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			armed_ff  <= 1'b0;
			offCnt_ff <= 32'h0;
		end else if (authPower) begin
			armed_ff  <= 1'b1;
			offCnt_ff <= 32'h0;
		end else if (armed_ff) begin
			offCnt_ff <= offCnt_ff + 32'h1;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	block_sideband_a: assert property (auxValid && (auxKind == `KVM_AUX_CEC ||
		auxKind == `KVM_AUX_HDCP || auxKind == `KVM_AUX_MCCS ||
		(auxKind == `KVM_AUX_EDID && auxDir != `KVM_DIR_TO_HOST)) |-> !auxPass)
		else $error("blocked sideband kind passed");
	pass_sideband_a: assert property (auxValid && (|ledPanel) && !secureState &&
		(auxKind == `KVM_AUX_LTRAIN || (auxDir == `KVM_DIR_TO_HOST &&
		(auxKind == `KVM_AUX_EDID || auxKind == `KVM_AUX_HPD))) |-> auxPass)
		else $error("allowed sideband kind blocked");
	tied_paths_a: assert property ((|kbdOutValid) && (|msOutValid) |->
		kbdOutValid == msOutValid && $onehot(msOutValid))
		else $error("keyboard and mouse on different hosts");
	panel_lamp_a: assert property ((|ledPanel) |-> ledPanel == (N'(1) << osdChan))
		else $error("panel lamp disagrees with channel");
	remote_lamp_a: assert property ((|ledRemote) |-> ledRemote == (N'(1) << osdChan))
		else $error("remote lamp disagrees with channel");
	switch_ends_a: assert property ((|ledPanel) && $past(|ledPanel) &&
		osdChan != $past(osdChan) |-> $past(authSessionEnd) && !authPower)
		else $error("switch without session end or power cut");
	end_pulse_a: assert property (authSessionEnd |=> !authSessionEnd)
		else $error("session end pulse too long");
	power_off_time_a: assert property (armed_ff && $rose(authPower) |->
		offCnt_ff >= AUTH_OFF_CYCLES)
		else $error("auth power restored too early");
	tamper_hold_a: assert property (tamperLatched |=> tamperLatched && secureState)
		else $error("tamper state not held");
	fail_blocks_a: assert property (secureState && $past(secureState) |->
		!(|kbdOutValid) && !(|msOutValid) && !(|uaHostValid) && !vidOutValid && !uaDevOutValid)
		else $error("data moved in secure state");
	fail_lamp_a: assert property (failLed |-> secureState && ledPanel == 0 && ledRemote == 0)
		else $error("fail lamp without shutdown");

	// Main scenarios reached
	cover property (authSessionEnd);
	cover property (armed_ff && $rose(authPower));
	cover property (failLed);
	cover property (auxValid && auxPass);
endmodule // kvm_switch_checker

bind kvm_secure_channel_switch_control kvm_switch_checker #(
	.N(N), .CW(CW), .AUTH_OFF_CYCLES(AUTH_OFF_CYCLES)
) i_chk (
	.clk_sys(clk_sys), .reset(reset), .auxValid(auxValid), .auxDir(auxDir),
	.auxKind(auxKind), .auxPass(auxPass), .kbdOutValid(kbdOutValid),
	.msOutValid(msOutValid), .uaHostValid(uaHostValid), .uaDevOutValid(uaDevOutValid),
	.vidOutValid(vidOutValid), .ledPanel(ledPanel), .ledRemote(ledRemote),
	.osdChan(osdChan), .authPower(authPower), .authSessionEnd(authSessionEnd),
	.failLed(failLed), .tamperLatched(tamperLatched), .secureState(secureState)
);

// File: verif/host_side_model.sv
// Host-side model: keyboard receivers that can stall, and host traffic to the auth device
`timescale 1ns/1ns
module host_side_model (
	// Clock and test control
	input  wire logic        clk_sys,
	input  wire logic        stall,
	// Keyboard stream from the block
	input  wire logic [3:0]  kbdOutValid,
	input  wire logic [7:0]  kbdOutData,
	output logic      [3:0]  kbdOutReady,
	// Host traffic toward the auth device
	output logic      [3:0]  uaHostInValid,
	output logic      [31:0] uaHostInData
);
	// ****************************************
	// Receiver behaviour
	// ****************************************
	logic [9:0] got[$];
	int         k;

	// Changes land after the falling edge so they are settled at the taking edge
	initial begin
		kbdOutReady = 4'h0;
		uaHostInValid = 4'h5;
		uaHostInData = 32'h5A4B_3C2D;
		forever begin
			@(negedge clk_sys);
			kbdOutReady = stall ? 4'h0 : 4'hF;
			uaHostInValid = ~uaHostInValid;  // Each host talks every other cycle, never idle-clean
			uaHostInData = ~uaHostInData;
		end
	end

	// Log each byte taken with the index of the host that took it
	always @(posedge clk_sys) begin
		for (k = 0; k < 4; k++)
			if (kbdOutValid[k] && kbdOutReady[k])
				got.push_back({k[1:0], kbdOutData});
	end
endmodule // host_side_model

// File: verif/test_kvm_secure_channel_switch_control.sv
// Self-checking bench for the channel switch control block
`timescale 1ns/1ns
module test_kvm_secure_channel_switch_control;
	// ****************************************
	// Signals and instances
	// ****************************************
	localparam int OFF = 50;
	logic        clk_sys, reset = 1, remoteAttached = 0, guardReqValid = 0, selfTestDone = 1;
	logic        selfTestPass = 1, tamperSense = 0, batteryFault = 0, tamperRecord = 0;
	logic        cardPresent = 1, authDevPresent = 1, kbdInValid = 0, msInValid = 0;
	logic        uaDevValid = 0, auxValid = 0, auxDir = 0, hpdDisplay = 1, stall = 0;
	logic [1:0]  guardReqChan = 0, osdChan;
	logic [2:0]  auxKind = 0;
	logic [3:0]  panelBtn = 0, remoteBtn = 0, vidInValid = 0, kbdOutReady, uaHostInValid;
	logic [3:0]  kbdOutValid, msOutValid, uaHostValid, hpdHost, ledPanel, ledRemote;
	logic [7:0]  kbdInData = 0, msInData = 0, uaDevData = 0, kbdOutData, msOutData;
	logic [7:0]  uaHostData, uaDevOutData, vidOutData;
	logic [31:0] vidInData = 0, uaHostInData;
	logic        kbdInReady, uaDevOutValid, authPower, authSessionEnd, vidOutValid;
	logic        auxPass, auxBlock, failLed, tamperLatched, secureState;
	int          fail_count = 0, cmp_count = 0;

	kvm_secure_channel_switch_control #(.AUTH_OFF_CYCLES(OFF), .DEBOUNCE_CYCLES(4)) i_dut (
		.clk_sys(clk_sys), .reset(reset), .panelBtn(panelBtn), .remoteBtn(remoteBtn),
		.remoteAttached(remoteAttached), .guardReqValid(guardReqValid),
		.guardReqChan(guardReqChan), .selfTestDone(selfTestDone), .selfTestPass(selfTestPass),
		.tamperSense(tamperSense), .batteryFault(batteryFault), .tamperRecord(tamperRecord),
		.cardPresent(cardPresent), .authDevPresent(authDevPresent), .kbdInValid(kbdInValid),
		.kbdInData(kbdInData), .kbdInReady(kbdInReady), .kbdOutValid(kbdOutValid),
		.kbdOutData(kbdOutData), .kbdOutReady(kbdOutReady), .msInValid(msInValid),
		.msInData(msInData), .msOutValid(msOutValid), .msOutData(msOutData),
		.uaDevValid(uaDevValid), .uaDevData(uaDevData), .uaHostValid(uaHostValid),
		.uaHostData(uaHostData), .uaHostInValid(uaHostInValid), .uaHostInData(uaHostInData),
		.uaDevOutValid(uaDevOutValid), .uaDevOutData(uaDevOutData), .authPower(authPower),
		.authSessionEnd(authSessionEnd), .vidInValid(vidInValid), .vidInData(vidInData),
		.vidOutValid(vidOutValid), .vidOutData(vidOutData), .auxValid(auxValid),
		.auxDir(auxDir), .auxKind(auxKind), .auxPass(auxPass), .auxBlock(auxBlock),
		.hpdDisplay(hpdDisplay), .hpdHost(hpdHost), .ledPanel(ledPanel),
		.ledRemote(ledRemote), .osdChan(osdChan), .failLed(failLed),
		.tamperLatched(tamperLatched), .secureState(secureState));

	host_side_model i_host (.clk_sys(clk_sys), .stall(stall), .kbdOutValid(kbdOutValid),
		.kbdOutData(kbdOutData), .kbdOutReady(kbdOutReady), .uaHostInValid(uaHostInValid),
		.uaHostInData(uaHostInData));

	// 100 MHz system clock
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(input string what, input logic [31:0] exp, input logic [31:0] act);
		cmp_count++;
		if (act !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, act);
		end
	endtask

	task end_of_test;
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task tmo(input string what);
		fail_count++;
		$display("BAD %s expected done seen timeout", what);
		end_of_test();
	endtask

	// Every task starts and ends just after a falling edge
	task doReset(input logic pass, input logic rec);
		reset = 1;
		selfTestPass = pass;
		tamperRecord = rec;
		repeat (8) @(negedge clk_sys);
		reset = 0;
		repeat (8) @(negedge clk_sys);
	endtask

	// Press, release after 15 falling edges, counting session ends and power-off cycles from the press on
	task swTo(input logic [3:0] vec, input logic rem, input int ch, input int nEnd);
		int i, ends, low;
		ends = 0;
		low = 0;
		if (rem) remoteBtn = vec;
		else panelBtn = vec;
		for (i = 0; i < 300 && !(i > 30 && authPower === 1'b1); i++) begin
			@(negedge clk_sys);
			if (i == 14) begin
				panelBtn = 0;
				remoteBtn = 0;
			end
			ends += (authSessionEnd === 1'b1);
			low += (authPower !== 1'b1);
		end
		if (i == 300) tmo("authPower");
		chk("channel", ch, osdChan);
		chk("lamp", 4'h1 << ch, ledPanel | ledRemote);
		chk("session ends", nEnd, ends);
		chk("power off cycles", nEnd > 0, nEnd > 0 ? low >= OFF : low != 0);
	endtask

	task kbdSend(input logic [7:0] b);
		int i;
		kbdInValid = 1;
		kbdInData = b;
		for (i = 0; i < 100 && kbdInReady !== 1'b1; i++) @(negedge clk_sys);
		if (i == 100) tmo("kbdInReady");
		@(negedge clk_sys);
		kbdInValid = 0;
		@(negedge clk_sys);
	endtask

	task endWait(input string what);
		int i, n;
		n = 0;
		for (i = 0; i < 10; i++) begin
			@(negedge clk_sys);
			n += (authSessionEnd === 1'b1);
		end
		chk(what, 1, n);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task auxScan;
		int k, d;
		auxValid = 1;
		for (k = 0; k < 6; k++)
			for (d = 0; d < 2; d++) begin
				auxKind = k[2:0];
				auxDir = d[0];
				#1;
				chk("aux pass", k == 2 || (k < 2 && d == 1), auxPass);
				chk("aux block", !(k == 2 || (k < 2 && d == 1)), auxBlock);
				@(negedge clk_sys);
			end
		auxValid = 0;
	endtask

	// Bytes stuck behind a stalled host must not survive a switch
	task kbdPurge;
		stall = 1;
		kbdSend(8'hA1);
		kbdSend(8'hA2);
		swTo(4'h4, 0, 2, 1);
		stall = 0;
		repeat (6) @(negedge clk_sys);
		chk("stale bytes", 0, i_host.got.size());
		kbdSend(8'hC3);
		repeat (3) @(negedge clk_sys);
		chk("fresh count", 1, i_host.got.size());
		chk("fresh byte", {2'd2, 8'hC3}, i_host.got.size() ? i_host.got[0] : 0);
	endtask

	task dataPaths;
		logic       v;
		logic [7:0] d;
		msInValid = 1;
		msInData = 8'h5A;
		uaDevValid = 1;
		uaDevData = 8'h77;
		vidInValid = 4'hF;
		vidInData = 32'h4433_2211;
		@(posedge clk_sys);
		v = uaHostInValid[2];
		d = uaHostInData[23:16];
		@(negedge clk_sys);
		chk("mouse valid", 4'h4, msOutValid);
		chk("auth data", 8'h77, uaHostData);
		chk("host auth valid", v, uaDevOutValid);
		chk("host auth data", d, uaDevOutData);
		chk("hot plug", 4'h4, hpdHost);
		chk("mouse data", 8'h5A, msOutData);
		chk("auth valid", 4'h4, uaHostValid);
		chk("video valid", 1, vidOutValid);
		chk("video data", 8'h33, vidOutData);
		msInValid = 0;
		uaDevValid = 0;
	endtask

	task remoteAuth;
		remoteAttached = 1;
		guardReqValid = 1;
		guardReqChan = 2;
		repeat (4) @(negedge clk_sys);
		swTo(4'h1, 0, 1, 0);
		guardReqValid = 0;
		swTo(4'h8, 1, 3, 1);
		chk("remote lamp", 4'h8, ledRemote);
	endtask

	task sessEnd;
		cardPresent = 0;
		endWait("card pulled");
		authDevPresent = 0;
		endWait("device pulled");
		cardPresent = 1;
		authDevPresent = 1;
		repeat (4) @(negedge clk_sys);
	endtask

	task tamper;
		selfTestPass = 0;
		repeat (4) @(negedge clk_sys);
		chk("late test ignored", 0, failLed);
		tamperSense = 1;
		msInValid = 1;
		repeat (4) @(negedge clk_sys);
		tamperSense = 0;
		repeat (4) @(negedge clk_sys);
		chk("tamper latch", 1, tamperLatched);
		chk("secure", 1, secureState);
		chk("lamps off", 0, ledPanel);
		chk("mouse blocked", 0, msOutValid);
		chk("video blocked", 0, vidOutValid);
		chk("kbd refused", 0, kbdInReady);
		msInValid = 0;
		doReset(1'b1, 1'b1);
		chk("record kept", 1, secureState);
	endtask

	task selfFail;
		doReset(1'b0, 1'b0);
		chk("fail lamp", 1, failLed);
		chk("stopped", 0, ledPanel);
		chk("secure", 1, secureState);
	endtask

	// Main sequence
	initial begin
		doReset(1'b1, 1'b0);
		chk("boot channel", 0, osdChan);
		chk("boot lamp", 4'h1, ledPanel);
		auxScan();
		kbdPurge();
		dataPaths();
		swTo(4'h4, 0, 2, 0);
		swTo(4'h6, 0, 1, 1);
		remoteAuth();
		sessEnd();
		tamper();
		selfFail();
		end_of_test();
	end
endmodule // test_kvm_secure_channel_switch_control
